// >>> include/bvm_defs.svh
// Offsets, reset values and timing counts of the bus level monitor
`ifndef BVM_DEFS_SVH
`define BVM_DEFS_SVH

`define BVM_CLK_HZ      25000000
`define BVM_OSC_HZ      20000
`define BVM_TICK_CYC    (`BVM_CLK_HZ / `BVM_OSC_HZ)

`define BVM_NUM_CMP     5
`define BVM_SAFE0_IDX   3'h4
`define BVM_THR_W       10
`define BVM_CNT_W       8

`define BVM_ADR_MATCH   8'h00
`define BVM_ADR_CHG     8'h04
`define BVM_ADR_CMP_EN  8'h08
`define BVM_ADR_DEB_PER 8'h0c
`define BVM_ADR_DEB_SEL 8'h10
`define BVM_ADR_PWR_STS 8'h14
`define BVM_ADR_PWR_EN  8'h18
`define BVM_ADR_THR0    8'h1c

`define BVM_VLD_BIT     8
`define BVM_EV_CHG_BIT  0
`define BVM_EV_VLD_BIT  1

`define BVM_RST_CMP_EN  5'h13
`define BVM_RST_DEB_SEL 5'h1f
`define BVM_RST_DEB_PER 8'h04
`define BVM_RST_THR0    10'h0a0
`define BVM_RST_THR1    10'h0c0
`define BVM_RST_THR2    10'h3ff
`define BVM_RST_THR3    10'h3ff
`define BVM_RST_SAFE0   10'h020

`endif

// >>> include/bvm_pkg.sv
// Types shared by the bus level monitor and its debouncer
`include "bvm_defs.svh"

package bvm_pkg;

  typedef logic [`BVM_THR_W-1:0] thr_t;

  typedef struct packed {
    logic                  stable;
    logic                  cand;
    logic                  valid;
    logic                  chg;
    logic [`BVM_CNT_W-1:0] cnt;
  } deb_s;

  typedef struct packed {
    logic                       sync1;
    logic                       sync2;
    logic [10:0]                div;
    logic                       tick;
    logic [2:0]                 idx;
    thr_t                       level;
    thr_t [`BVM_NUM_CMP-1:0]    thr;
    logic [`BVM_NUM_CMP-1:0]    cmp_en;
    logic [`BVM_NUM_CMP-1:0]    deb_sel;
    logic [`BVM_CNT_W-1:0]      deb_per;
    logic [`BVM_NUM_CMP-1:0]    chg;
    logic [1:0]                 pwr_sts;
    logic [1:0]                 pwr_en;
    logic                       vld;
    logic                       restart;
    logic                       ack;
    logic [31:0]                dat;
    logic                       irq_n;
  } mon_s;

endpackage

// >>> core/bus_level_debouncer.sv
// One comparison channel's debouncer with restart
`timescale 1ns/10ps
`default_nettype none
`include "bvm_defs.svh"

module bus_level_debouncer
  import bvm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control
  input  wire logic                  restart_i,
  input  wire logic                  sample_i,
  input  wire logic                  raw_i,
  input  wire logic                  deb_en_i,
  input  wire logic [`BVM_CNT_W-1:0] period_i,
  // Result
  output logic                       stable_o,
  output logic                       valid_o,
  output logic                       chg_o
);

  deb_s st_ff;
  deb_s nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.chg = 1'b0;
    if (restart_i) begin
      nxt_st.valid = 1'b0;
      nxt_st.cnt   = '0;
      nxt_st.cand  = st_ff.stable;
    end else if (sample_i) begin
      if (!deb_en_i) begin
        // Not selected: result passes straight through
        nxt_st.cand   = raw_i;
        nxt_st.cnt    = '0;
        nxt_st.stable = raw_i;
        nxt_st.valid  = 1'b1;
        nxt_st.chg    = raw_i != st_ff.stable;
      end else if (raw_i != st_ff.cand) begin
        nxt_st.cand = raw_i;
        nxt_st.cnt  = '0;
      end else if (st_ff.cnt >= period_i) begin
        nxt_st.stable = raw_i;
        nxt_st.valid  = 1'b1;
        nxt_st.chg    = raw_i != st_ff.stable;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stable_o = st_ff.stable;
  assign valid_o  = st_ff.valid;
  assign chg_o    = st_ff.chg;

  stable_on_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(st_ff.stable) |-> $past(sample_i))
    else $error("debounced level moved without a sample");

  toggle_resets_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_i && !restart_i && deb_en_i && raw_i != st_ff.cand)
      |=> st_ff.cnt == '0 && !chg_o)
    else $error("toggling result did not restart debounce count");

  restart_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    restart_i |=> !valid_o)
    else $error("restart left the debounced result valid");

endmodule

`default_nettype wire

// >>> core/bus_voltage_threshold_monitor.sv
// Bus voltage threshold monitor with Wishbone registers and interrupt
//
// Function
// - Four bus thresholds; 0 and 1 bracket 5V, 2 and 3 higher ranges.
// - Separate programmable threshold detects the safe zero volt level.
// - Twenty kilohertz tick steps through five comparisons one at a time.
// - Match and change bits of debounce-selected thresholds update only after the programmed debounce period.
// - Match bit set when sensed bus voltage is above its threshold.
// - Match change raises active low interrupt when enabled.
// - Debounce select chooses per threshold which results get debounced.
// - Any threshold write restarts the debouncer.
// - Valid with no match bits means bus below safe zero level.
// - Later crossings of enabled thresholds update flags and interrupt.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bvm_defs.svh"

module bus_voltage_threshold_monitor
  import bvm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Shared comparator
  input  wire logic        bus_sense_input_i,
  output logic      [9:0]  thr_level_o,
  output logic      [2:0]  thr_index_o,
  // Interrupt
  output logic             irq_n_o
);

  mon_s st_ff;
  mon_s nxt_st;

  logic [`BVM_NUM_CMP-1:0] deb_stable;
  logic [`BVM_NUM_CMP-1:0] deb_valid;
  logic [`BVM_NUM_CMP-1:0] deb_chg;
  logic [`BVM_NUM_CMP-1:0] bus_level_match_bits;
  logic [`BVM_NUM_CMP-1:0] chg_set;
  logic [31:0]             wmask;
  logic                    req;
  logic                    wr;
  logic                    thr_wr;
  logic                    all_valid;

  assign req   = wb_cyc_i && wb_stb_i;
  assign wr    = req && wb_we_i && st_ff.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Above threshold and enabled
  assign bus_level_match_bits = deb_stable & st_ff.cmp_en;
  assign chg_set   = deb_chg & st_ff.cmp_en;
  assign all_valid = &(deb_valid | ~st_ff.cmp_en);

  genvar g;
  generate
    for (g = 0; g < `BVM_NUM_CMP; g++) begin : gen_ch
      bus_level_debouncer u_deb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (st_ff.restart),
        .sample_i  (st_ff.tick && st_ff.idx == 3'(g)),
        .raw_i     (st_ff.sync2),
        .deb_en_i  (st_ff.deb_sel[g]),
        .period_i  (st_ff.deb_per),
        .stable_o  (deb_stable[g]),
        .valid_o   (deb_valid[g]),
        .chg_o     (deb_chg[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_st         = st_ff;
    thr_wr         = 1'b0;
    nxt_st.restart = 1'b0;
    nxt_st.sync1   = bus_sense_input_i;
    nxt_st.sync2   = st_ff.sync1;

    // Sequencer: one comparison per oscillator tick
    nxt_st.tick = 1'b0;
    if (st_ff.div == 11'(`BVM_TICK_CYC - 1)) begin
      nxt_st.div  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end
    if (st_ff.tick) begin
      if (st_ff.idx == `BVM_SAFE0_IDX) begin
        nxt_st.idx = '0;
      end else begin
        nxt_st.idx = st_ff.idx + 1'b1;
      end
    end

    // Wishbone: ack one cycle after request, write at ack edge
    nxt_st.ack = req && !st_ff.ack;
    nxt_st.dat = '0;
    case (wb_adr_i)
      `BVM_ADR_MATCH: begin
        nxt_st.dat[`BVM_NUM_CMP-1:0] = bus_level_match_bits;
        nxt_st.dat[`BVM_VLD_BIT]     = st_ff.vld;
      end
      `BVM_ADR_CHG:     nxt_st.dat[`BVM_NUM_CMP-1:0] = st_ff.chg;
      `BVM_ADR_CMP_EN:  nxt_st.dat[`BVM_NUM_CMP-1:0] = st_ff.cmp_en;
      `BVM_ADR_DEB_PER: nxt_st.dat[`BVM_CNT_W-1:0]   = st_ff.deb_per;
      `BVM_ADR_DEB_SEL: nxt_st.dat[`BVM_NUM_CMP-1:0] = st_ff.deb_sel;
      `BVM_ADR_PWR_STS: nxt_st.dat[1:0] = st_ff.pwr_sts;
      `BVM_ADR_PWR_EN:  nxt_st.dat[1:0] = st_ff.pwr_en;
      default: begin
        // Threshold 0..3 then safe zero, one word each
        for (int i = 0; i < `BVM_NUM_CMP; i++) begin
          if (wb_adr_i == `BVM_ADR_THR0 + 8'(4 * i)) begin
            nxt_st.dat[`BVM_THR_W-1:0] = st_ff.thr[i];
          end
        end
      end
    endcase
    if (!(req && !st_ff.ack)) begin
      nxt_st.dat = '0;
    end

    if (wr) begin
      case (wb_adr_i)
        `BVM_ADR_CMP_EN: nxt_st.cmp_en =
          (st_ff.cmp_en & ~wmask[4:0]) | (wb_dat_i[4:0] & wmask[4:0]);
        `BVM_ADR_DEB_PER: nxt_st.deb_per =
          (st_ff.deb_per & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        `BVM_ADR_DEB_SEL: nxt_st.deb_sel =
          (st_ff.deb_sel & ~wmask[4:0]) | (wb_dat_i[4:0] & wmask[4:0]);
        `BVM_ADR_PWR_EN: nxt_st.pwr_en =
          (st_ff.pwr_en & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
        `BVM_ADR_CHG:
          nxt_st.chg = st_ff.chg & ~(wb_dat_i[4:0] & wmask[4:0]);
        `BVM_ADR_PWR_STS:
          nxt_st.pwr_sts = st_ff.pwr_sts & ~(wb_dat_i[1:0] & wmask[1:0]);
        default: begin
          for (int i = 0; i < `BVM_NUM_CMP; i++) begin
            if (wb_adr_i == `BVM_ADR_THR0 + 8'(4 * i)) begin
              thr_wr        = 1'b1;
              nxt_st.thr[i] = (st_ff.thr[i] & ~wmask[9:0]) |
                              (wb_dat_i[9:0] & wmask[9:0]);
            end
          end
        end
      endcase
    end

    // New thresholds restart evaluation
    if (thr_wr) begin
      nxt_st.restart = 1'b1;
      nxt_st.vld     = 1'b0;
    end else if (!st_ff.restart) begin
      nxt_st.vld = all_valid;
    end

    // Hardware sets win over software clears
    nxt_st.chg = nxt_st.chg | chg_set;
    if (|chg_set) begin
      nxt_st.pwr_sts[`BVM_EV_CHG_BIT] = 1'b1;
    end
    if (nxt_st.vld && !st_ff.vld) begin
      nxt_st.pwr_sts[`BVM_EV_VLD_BIT] = 1'b1;
    end

    nxt_st.level = nxt_st.thr[nxt_st.idx];
    nxt_st.irq_n = ~|(nxt_st.pwr_sts & nxt_st.pwr_en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff         <= '0;
      st_ff.cmp_en  <= `BVM_RST_CMP_EN;
      st_ff.deb_sel <= `BVM_RST_DEB_SEL;
      st_ff.deb_per <= `BVM_RST_DEB_PER;
      st_ff.thr[0]  <= `BVM_RST_THR0;
      st_ff.thr[1]  <= `BVM_RST_THR1;
      st_ff.thr[2]  <= `BVM_RST_THR2;
      st_ff.thr[3]  <= `BVM_RST_THR3;
      st_ff.thr[4]  <= `BVM_RST_SAFE0;
      st_ff.level   <= `BVM_RST_THR0;
      st_ff.irq_n   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o    = st_ff.dat;
  assign wb_ack_o    = st_ff.ack;
  assign thr_level_o = st_ff.level;
  assign thr_index_o = st_ff.idx;
  assign irq_n_o     = st_ff.irq_n;

  // Checks

  ack_single_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_after_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.tick |=> (!st_ff.tick) [*8])
    else $error("sequencer ticks too close together");

  index_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.tick && st_ff.idx == `BVM_SAFE0_IDX) |=> st_ff.idx == 3'h0)
    else $error("sequencer did not wrap after five comparisons");

  level_follows_index_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $changed(st_ff.idx) |-> thr_level_o == st_ff.thr[st_ff.idx])
    else $error("comparator level does not match selected threshold");

  thr_write_restart_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    thr_wr |=> st_ff.restart && !st_ff.vld ##1 !st_ff.vld)
    else $error("threshold write did not restart validation");

  change_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|chg_set) |=> ((st_ff.chg & $past(chg_set)) == $past(chg_set))
      && st_ff.pwr_sts[`BVM_EV_CHG_BIT])
    else $error("match change lost from change flags");

  irq_on_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|chg_set && st_ff.pwr_en[`BVM_EV_CHG_BIT]) |=> !irq_n_o)
    else $error("enabled change did not assert interrupt");

  match_enabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(bus_level_match_bits) |-> $past(st_ff.tick) ||
      $changed(st_ff.cmp_en))
    else $error("match bits moved outside a comparison");

  // Bus data, index and divider range, flag and enable writes
  idle_data_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");

  index_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    thr_index_o <= `BVM_SAFE0_IDX)
    else $error("comparison index beyond safe zero slot");

  tick_divider_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.div < 11'(`BVM_TICK_CYC))
    else $error("tick divider ran past its period");

  valid_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_ff.vld) |-> st_ff.pwr_sts[`BVM_EV_VLD_BIT])
    else $error("match valid rose without a power event");

  change_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `BVM_ADR_CHG && wb_sel_i[0] && chg_set == '0)
      |=> (st_ff.chg & $past(wb_dat_i[4:0])) == '0)
    else $error("written one did not clear change flag");

  enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == `BVM_ADR_CMP_EN && wb_sel_i[0])
      |=> st_ff.cmp_en == $past(wb_dat_i[4:0]))
    else $error("compare enable write did not land");

  change_enabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st_ff.chg & ~$past(st_ff.chg)) & ~$past(st_ff.cmp_en)) == '0)
    else $error("change flag set for a disabled threshold");

  valid_rise_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_ff.vld));

  irq_assert_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(irq_n_o));

  below_safe_zero_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff.vld && bus_level_match_bits == '0);

  restart_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff.restart && bus_level_match_bits != '0);

  debounced_change_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (chg_set & st_ff.deb_sel) != '0);

endmodule

`default_nettype wire

// >>> test/bus_sense_divider.sv
// Behavioural bus sense divider and shared comparator
`timescale 1ns/10ps
`default_nettype none

module bus_sense_divider (
  // Bus level in threshold units
  input  wire logic [9:0] bus_level_i,
  // Threshold presented by the monitor
  input  wire logic [9:0] thr_level_i,
  // Comparator result
  output logic            above_o
);
  // High while the divided bus sits above the threshold
  assign above_o = (bus_level_i > thr_level_i);
endmodule

`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the bus voltage threshold monitor
`timescale 1ns/10ps
`default_nettype none
`include "bvm_defs.svh"

module testbench
  import bvm_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq_n, sense;
  logic [7:0]  adr;
  logic [3:0]  sel, sel_m;
  logic [31:0] wdat, rdat;
  logic [9:0]  level, volt;
  logic [2:0]  idx;
  int          err_total, checked, cycles;

  bus_voltage_threshold_monitor i_bus_voltage_threshold_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .bus_sense_input_i(sense),
    .thr_level_o(level), .thr_index_o(idx), .irq_n_o(irq_n));

  bus_sense_divider i_bus_sense_divider (
    .bus_level_i(volt), .thr_level_i(level), .above_o(sense));

  always #20 clk_i = ~clk_i;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= sel_m;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wait_match(input logic [31:0] exp);
    logic [31:0] q;
    int n;
    n = 0;
    q = '0;
    while (q !== exp && n < 6000) begin
      wb(1'b0, `BVM_ADR_MATCH, 32'h0, q);
      n++;
    end
    check(q, exp);
    check({31'h0, irq_n}, 32'h0);
  endtask

  task automatic clear_all();
    wr(`BVM_ADR_CHG, 32'h1f);
    wr(`BVM_ADR_PWR_STS, 32'h3);
    rd_chk(`BVM_ADR_PWR_STS, 32'h0);
    check({31'h0, irq_n}, 32'h1);
  endtask

  task automatic t_reset();
    logic [7:0]  a [9] = '{`BVM_ADR_CMP_EN, `BVM_ADR_DEB_PER,
      `BVM_ADR_DEB_SEL, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h40};
    logic [31:0] e [9] = '{32'h13, 32'h04, 32'h1f, 32'h0a0, 32'h0c0,
      32'h3ff, 32'h3ff, 32'h020, 32'h0};
    logic [2:0]  p;
    wr(8'h40, 32'hffff);
    for (int i = 0; i < 9; i++) begin
      rd_chk(a[i], e[i]);
    end
    for (int i = 0; i < 6; i++) begin
      p = idx;
      @(posedge clk_i);
      while (idx === p) @(posedge clk_i);
      check({29'h0, idx}, (p == 3'h4) ? 32'h0 : {29'h0, p + 3'h1});
      check({22'h0, level}, e[3 + idx]);
    end
    // Byte lane 1 only: upper threshold bits change, lower bits kept
    sel_m = 4'h2;
    wr(`BVM_ADR_THR0, 32'hffff);
    sel_m = 4'hf;
    rd_chk(`BVM_ADR_THR0, 32'h3a0);
    wr(`BVM_ADR_THR0, 32'h0a0);
    $display("test reset done");
  endtask

  task automatic t_start();
    volt <= 10'h0b0;
    wr(`BVM_ADR_PWR_EN, 32'h3);
    wr(`BVM_ADR_DEB_SEL, 32'h0);
    wr(`BVM_ADR_DEB_PER, 32'h0);
    wr(`BVM_ADR_THR0, 32'h0a0);
    rd_chk(`BVM_ADR_MATCH, 32'h0);
    wait_match(32'h111);
    rd_chk(`BVM_ADR_CHG, 32'h11);
    clear_all();
    $display("test start done");
  endtask

  task automatic t_raise();
    logic [31:0] q;
    volt <= 10'h120;
    wr(`BVM_ADR_CMP_EN, 32'h1f);
    wr(`BVM_ADR_DEB_SEL, 32'h0c);
    wr(8'h24, 32'h100);
    wr(8'h28, 32'h140);
    wb(1'b0, `BVM_ADR_MATCH, 32'h0, q);
    check({31'h0, q[`BVM_VLD_BIT]}, 32'h0);
    wait_match(32'h117);
    clear_all();
    $display("test raise done");
  endtask

  task automatic t_zero();
    logic [31:0] q;
    volt <= 10'h010;
    wr(8'h2c, 32'h020);
    wb(1'b0, `BVM_ADR_MATCH, 32'h0, q);
    check({31'h0, q[`BVM_VLD_BIT]}, 32'h0);
    wait_match(32'h100);
    clear_all();
    $display("test zero done");
  endtask

  task automatic t_later();
    int n;
    volt <= 10'h0b0;
    n = 0;
    while (irq_n !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    check({31'h0, irq_n}, 32'h0);
    wait_match(32'h111);
    rd_chk(`BVM_ADR_CHG, 32'h11);
    $display("test later done");
  endtask

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h0; sel = 4'h0; wdat = 32'h0; volt = 10'h0b0;
    err_total = 0; checked = 0; cycles = 0; sel_m = 4'hf;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_start();
    t_raise();
    t_zero();
    t_later();
    conclude();
  end
endmodule

`default_nettype wire
